// [shared/fpr_pkg.sv]
package fpr_pkg;
  // Register offsets on the 8-bit register port
  localparam logic [7:0] FLOOR1_OFS = 8'h64;
  localparam logic [7:0] FLOOR2_OFS = 8'h65;
  localparam logic [7:0] FLOOR3_OFS = 8'h66;
  localparam logic [7:0] SMOOTH_OFS = 8'h63;
  localparam logic [7:0] DUTY1_OFS = 8'h50;
  localparam logic [7:0] DUTY2_OFS = 8'h51;
  localparam logic [7:0] DUTY3_OFS = 8'h52;
  localparam logic [7:0] UNMAPPED_VAL = 8'h00;
  // Reset values and the off duty code
  localparam logic [7:0] FLOOR_RST = 8'h80;
  localparam logic [7:0] SMOOTH_RST = 8'h00;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [7:0] DUTY_OFF = 8'h00;
  // Smoothing register fields
  localparam int SMOOTH_EN_BIT = 3;
  localparam int RATE_LSB = 0;
  localparam int RATE_W = 3;
  localparam logic [7:0] SMOOTH_WMASK = 8'h0F;
  // Duty increments per code
  localparam logic [7:0] STEP_C0 = 8'h01;
  localparam logic [7:0] STEP_C1 = 8'h02;
  localparam logic [7:0] STEP_C2 = 8'h03;
  localparam logic [7:0] STEP_C3 = 8'h04;
  localparam logic [7:0] STEP_C4 = 8'h08;
  localparam logic [7:0] STEP_C5 = 8'h0C;
  localparam logic [7:0] STEP_C6 = 8'h18;
  localparam logic [7:0] STEP_C7 = 8'h30;
  // Time slot lengths: full 255-code ramp at increment 1, divided by 255 (us)
  localparam int CLK_MHZ = 40;
  localparam int SLOT_NORM_US = 147059;
  localparam int SLOT_SLOW_US = 204706;
  localparam int SLOT_NORM_CYC = SLOT_NORM_US * CLK_MHZ;
  localparam int SLOT_SLOW_CYC = SLOT_SLOW_US * CLK_MHZ;
endpackage

// [core/fpr_slot_timer.sv]
`timescale 1ns/1ps
module fpr_slot_timer
  import fpr_pkg::*;
#(
  parameter int NORM_CYC = SLOT_NORM_CYC,
  parameter int SLOW_CYC = SLOT_SLOW_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  output logic slot_o
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic [31:0] limit;
  logic next_slot;

  // Refuse slot lengths the counter cannot serve
  if (NORM_CYC < 2 || SLOW_CYC < 2)
  begin : g_bad_len
    $error("fpr_slot_timer: slot length below two cycles");
  end

  // Slot divider, length chosen by the timebase bit
  always_comb
  begin
    limit = slow_i ? 32'(SLOW_CYC - 1) : 32'(NORM_CYC - 1); // R3 R4
    next_slot = 1'b0;
    next_cnt = cnt + 32'h0000_0001;
    if (cnt >= limit)
    begin
      next_cnt = 32'h0000_0000;
      next_slot = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt <= 32'h0000_0000;
      slot_o <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      slot_o <= next_slot;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_slot_single: assert property (slot_o |=> !slot_o) // R12
    else $error("slot pulse longer than one cycle");
  chk_slot_gap: assert property (slot_o |=> !slot_o [*1] ##0 (cnt == 32'h0000_0001)) // R3
    else $error("slot counter did not restart after pulse");
endmodule

// [core/fpr_floor_ramp.sv]
// Strobed register access was decided locally.
`timescale 1ns/1ps
// Functional notes
// [R1] Remote-2 smoothing enable limits duty rate
// [R2] Rate code picks step 1,2,3,4,8,12,24,48
// [R3] Slow timebase: full ramp 52.2 s slowest
// [R4] Normal timebase: fastest full ramp 0.8 s
// [R5] Lock bit freezes smoothing register writes
// [R6] Three 8-bit floor duty registers, consecutive
// [R7] Floor registers reset to half duty
// [R8] Floor code maps linearly to duty
// [R9] Floor registers read-only in automatic mode
// [R10] Smoothing ramps gradually toward new target
// [R11] Above start temperature, run at least floor
// [R12] One step per slot, never overshoot
module fpr_floor_ramp
  import fpr_pkg::*;
#(
  parameter int NORM_CYC = SLOT_NORM_CYC,
  parameter int SLOW_CYC = SLOT_SLOW_CYC
)
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic auto_mode_i,
  input wire logic lock_i,
  input wire logic ramp_timebase_i,
  input wire logic [2:0] remote2_owner_i,
  input wire logic [2:0] above_start_i,
  input wire logic [7:0] auto_target1_i,
  input wire logic [7:0] auto_target2_i,
  input wire logic [7:0] auto_target3_i,
  output logic [7:0] fan_drive_output1_o,
  output logic [7:0] fan_drive_output2_o,
  output logic [7:0] fan_drive_output3_o
);
  logic rst_meta;
  logic rst_n;
  logic slot;
  logic [7:0] floor_duty [3];
  logic [7:0] next_floor_duty [3];
  logic [7:0] smooth_cfg;
  logic [7:0] next_smooth_cfg;
  logic [7:0] duty [3];
  logic [7:0] next_duty [3];
  logic [7:0] tgt [3];
  logic [7:0] raw_tgt [3];
  logic [2:0] ramp_on;
  logic [7:0] step;
  logic smooth_en;
  logic [7:0] next_rdata;

  // Duty increment for a rate code
  function automatic logic [7:0] rate_step(input logic [RATE_W-1:0] code);
    logic [7:0] s;
    s = STEP_C0;
    case (code)
      3'h0: s = STEP_C0;
      3'h1: s = STEP_C1;
      3'h2: s = STEP_C2;
      3'h3: s = STEP_C3;
      3'h4: s = STEP_C4;
      3'h5: s = STEP_C5;
      3'h6: s = STEP_C6;
      3'h7: s = STEP_C7;
      default: s = STEP_C0;
    endcase
    return s;
  endfunction

  // Move one step toward the target, clamped at it
  function automatic logic [7:0] step_toward(input logic [7:0] cur,
                                             input logic [7:0] dst,
                                             input logic [7:0] st);
    logic [8:0] sum;
    logic [7:0] res;
    sum = {1'b0, cur} + {1'b0, st};
    res = cur;
    if (cur < dst)
    begin
      res = (sum >= {1'b0, dst}) ? dst : sum[7:0];
    end
    else if (cur > dst)
    begin
      res = ((cur - dst) <= st) ? dst : 8'(cur - st);
    end
    return res;
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Slot pulse for the ramp
  fpr_slot_timer #(
    .NORM_CYC(NORM_CYC),
    .SLOW_CYC(SLOW_CYC)
  ) u_slot (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .slow_i(ramp_timebase_i),
    .slot_o(slot)
  );

  // Register writes with lock and mode gating
  always_comb
  begin
    next_smooth_cfg = smooth_cfg;
    for (int i = 0; i < 3; i++)
    begin
      next_floor_duty[i] = floor_duty[i];
    end
    if (wr_i && !auto_mode_i) // R9
    begin
      if (addr_i == FLOOR1_OFS) next_floor_duty[0] = wdata_i; // R6
      if (addr_i == FLOOR2_OFS) next_floor_duty[1] = wdata_i; // R6
      if (addr_i == FLOOR3_OFS) next_floor_duty[2] = wdata_i; // R6
    end
    if (wr_i && !lock_i && addr_i == SMOOTH_OFS) // R5
    begin
      next_smooth_cfg = wdata_i & SMOOTH_WMASK;
    end
  end

  // Register read mux, data one cycle later
  always_comb
  begin
    next_rdata = UNMAPPED_VAL;
    if (rd_i)
    begin
      case (addr_i)
        FLOOR1_OFS: next_rdata = floor_duty[0];
        FLOOR2_OFS: next_rdata = floor_duty[1];
        FLOOR3_OFS: next_rdata = floor_duty[2];
        SMOOTH_OFS: next_rdata = smooth_cfg;
        DUTY1_OFS: next_rdata = duty[0];
        DUTY2_OFS: next_rdata = duty[1];
        DUTY3_OFS: next_rdata = duty[2];
        default: next_rdata = UNMAPPED_VAL;
      endcase
    end
  end

  // Register storage
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 3; i++)
      begin
        floor_duty[i] <= FLOOR_RST; // R7
      end
      smooth_cfg <= SMOOTH_RST;
      rdata_o <= UNMAPPED_VAL;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        floor_duty[i] <= next_floor_duty[i];
      end
      smooth_cfg <= next_smooth_cfg;
      rdata_o <= next_rdata;
    end
  end

  // Smoothing controls
  assign smooth_en = smooth_cfg[SMOOTH_EN_BIT];
  assign step = rate_step(smooth_cfg[RATE_LSB +: RATE_W]); // R2
  assign raw_tgt[0] = auto_target1_i;
  assign raw_tgt[1] = auto_target2_i;
  assign raw_tgt[2] = auto_target3_i;

  // Target per channel and ramp selection
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      tgt[i] = raw_tgt[i];
      if (auto_mode_i)
      begin
        if (!above_start_i[i])
        begin
          tgt[i] = DUTY_OFF;
        end
        else if (raw_tgt[i] < floor_duty[i]) // R11
        begin
          tgt[i] = floor_duty[i];
        end
      end
      ramp_on[i] = auto_mode_i && smooth_en && remote2_owner_i[i]; // R1
    end
  end

  // Duty update: direct step or slotted ramp
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      next_duty[i] = tgt[i]; // R1
      if (ramp_on[i])
      begin
        next_duty[i] = slot ? step_toward(duty[i], tgt[i], step) : duty[i]; // R10 R12
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 3; i++)
      begin
        duty[i] <= DUTY_RST;
      end
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        duty[i] <= next_duty[i];
      end
    end
  end

  // Duty code goes straight to the drive outputs
  assign fan_drive_output1_o = duty[0]; // R8
  assign fan_drive_output2_o = duty[1]; // R8
  assign fan_drive_output3_o = duty[2]; // R8

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  chk_floor_auto_hold: assert property ( // R9
    auto_mode_i && wr_i && addr_i == FLOOR2_OFS |=> $stable(floor_duty[1]))
    else $error("floor register changed in automatic mode");
  chk_floor_write: assert property ( // R6
    !auto_mode_i && wr_i && addr_i == FLOOR3_OFS |=> floor_duty[2] == $past(wdata_i))
    else $error("floor register write lost");
  chk_smooth_lock: assert property ( // R5
    lock_i && wr_i && addr_i == SMOOTH_OFS |=> $stable(smooth_cfg))
    else $error("smoothing register changed while locked");
  chk_floor_reset: assert property ( // R7
    $rose(rst_n) |-> floor_duty[0] == FLOOR_RST && floor_duty[1] == FLOOR_RST &&
      floor_duty[2] == FLOOR_RST)
    else $error("floor register not at half duty after reset");
  chk_direct_follow: assert property ( // R1
    !ramp_on[0] |=> fan_drive_output1_o == $past(tgt[0]))
    else $error("unsmoothed channel did not follow target");
  chk_ramp_idle: assert property ( // R12
    ramp_on[0] && !slot |=> $stable(duty[0]))
    else $error("ramp moved outside a slot");
  chk_step_bound: assert property ( // R2
    ramp_on[0] && slot && duty[0] < tgt[0] |=>
      duty[0] > $past(duty[0]) && (duty[0] - $past(duty[0])) <= $past(step))
    else $error("ramp step out of range");
  chk_no_overshoot: assert property ( // R10
    ramp_on[0] && slot && duty[0] > tgt[0] |=> duty[0] >= $past(tgt[0]))
    else $error("ramp went below target");
  chk_floor_min: assert property ( // R11
    auto_mode_i && above_start_i[2] && !ramp_on[2] |=> fan_drive_output3_o >= $past(floor_duty[2]))
    else $error("auto duty below floor");
  chk_read_floor: assert property ( // R8
    rd_i && addr_i == FLOOR1_OFS |=> rdata_o == $past(floor_duty[0]))
    else $error("floor readback wrong");

  // Register port checks
  chk_rdata_idle: assert property ( // R6
    !rd_i |=> rdata_o == UNMAPPED_VAL)
    else $error("read data did not return to zero");
  chk_read_smooth: assert property ( // R5
    rd_i && addr_i == SMOOTH_OFS |=> rdata_o == $past(smooth_cfg))
    else $error("smoothing readback wrong");
  chk_read_duty: assert property ( // R8
    rd_i && addr_i == DUTY2_OFS |=> rdata_o == $past(duty[1]))
    else $error("duty readback wrong");
  chk_smooth_write: assert property ( // R5
    !lock_i && wr_i && addr_i == SMOOTH_OFS |=>
      smooth_cfg == ($past(wdata_i) & SMOOTH_WMASK))
    else $error("smoothing register write lost");
  chk_floor_hold_ch1: assert property ( // R9
    auto_mode_i && wr_i && addr_i == FLOOR1_OFS |=> $stable(floor_duty[0]))
    else $error("floor 1 changed in automatic mode");
  chk_floor_hold_ch3: assert property ( // R9
    auto_mode_i && wr_i && addr_i == FLOOR3_OFS |=> $stable(floor_duty[2]))
    else $error("floor 3 changed in automatic mode");
  chk_floor_write_ch1: assert property ( // R6
    !auto_mode_i && wr_i && addr_i == FLOOR1_OFS |=> floor_duty[0] == $past(wdata_i))
    else $error("floor 1 write lost");
  chk_floor_write_ch2: assert property ( // R6
    !auto_mode_i && wr_i && addr_i == FLOOR2_OFS |=> floor_duty[1] == $past(wdata_i))
    else $error("floor 2 write lost");
  chk_floor_keep: assert property ( // R6
    !wr_i |=> $stable(floor_duty[0]) && $stable(floor_duty[1]) &&
      $stable(floor_duty[2]))
    else $error("floor register changed without a write");
  chk_smooth_keep: assert property ( // R5
    !wr_i |=> $stable(smooth_cfg))
    else $error("smoothing register changed without a write");

  // Target and ramp checks
  chk_below_start_off: assert property ( // R11
    auto_mode_i && !above_start_i[0] && !ramp_on[0] |=>
      fan_drive_output1_o == DUTY_OFF)
    else $error("fan running below start temperature");
  chk_floor_min_ch1: assert property ( // R11
    auto_mode_i && above_start_i[0] && !ramp_on[0] |=>
      fan_drive_output1_o >= $past(floor_duty[0]))
    else $error("auto duty below floor on channel 1");
  chk_step_down: assert property ( // R2
    ramp_on[0] && slot && duty[0] > tgt[0] |=>
      duty[0] < $past(duty[0]) && ($past(duty[0]) - duty[0]) <= $past(step))
    else $error("ramp down step out of range");
  chk_step_exact: assert property ( // R2
    ramp_on[0] && slot && duty[0] < tgt[0] && (tgt[0] - duty[0]) > step |=>
      duty[0] == $past(duty[0]) + $past(step))
    else $error("ramp step not the selected increment");
  chk_ramp_reach: assert property ( // R12
    ramp_on[0] && slot && duty[0] < tgt[0] && (tgt[0] - duty[0]) <= step |=>
      duty[0] == $past(tgt[0]))
    else $error("ramp did not stop at target");
  chk_follow_ch2: assert property ( // R1
    !ramp_on[1] |=> fan_drive_output2_o == $past(tgt[1]))
    else $error("unsmoothed channel 2 did not follow target");
  chk_follow_ch3: assert property ( // R1
    !ramp_on[2] |=> fan_drive_output3_o == $past(tgt[2]))
    else $error("unsmoothed channel 3 did not follow target");
  chk_manual_follow: assert property ( // R1
    !auto_mode_i |=> fan_drive_output1_o == $past(auto_target1_i))
    else $error("manual duty did not follow input");

  cov_ramp_reach: cover property (ramp_on[0] && slot ##1 duty[0] == tgt[0]);
  cov_lock_write: cover property (lock_i && wr_i && addr_i == SMOOTH_OFS);
  cov_auto_floor: cover property (auto_mode_i && wr_i && addr_i == FLOOR1_OFS);
  cov_ramp_down: cover property (ramp_on[0] && slot && duty[0] > tgt[0]);
endmodule

// [verification/fpr_fan_model.sv]
`timescale 1ns/1ps
// Fan motor on one drive output: it turns whenever its duty code is nonzero
module fpr_fan_model
(
  input wire logic clk_i,
  input wire logic [7:0] duty_i,
  output logic spin_o
);
  // One cycle of motor lag behind the duty code
  always_ff @(posedge clk_i)
    spin_o <= (duty_i != 8'h00);
endmodule

// [verification/fpr_floor_ramp_test.sv]
`timescale 1ns/1ps
module fpr_floor_ramp_test;
  import fpr_pkg::*;
  localparam int NC = 20;
  localparam int SC = 28;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00;
  logic wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0;
  logic auto_mode_i = 1'b0, lock_i = 1'b0, ramp_timebase_i = 1'b0;
  logic [2:0] remote2_owner_i = 3'h0, above_start_i = 3'h0;
  logic [7:0] t1 = 8'h00, t2 = 8'h00, t3 = 8'h00, rdata_o, f1, f2, f3;
  logic [7:0] last1 = 8'h00, m, r, s;
  logic [15:0] n;
  logic spin;
  logic [15:0] rq[$];
  logic [7:0] fq[$];
  int chg[$];
  int miscompares = 0, cmp_count = 0, cyc = 0, seed = 43;
  logic [7:0] stp [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0C, 8'h18, 8'h30};

  fpr_floor_ramp #(.NORM_CYC(NC), .SLOW_CYC(SC)) u_fpr_floor_ramp (
    .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .auto_mode_i(auto_mode_i),
    .lock_i(lock_i), .ramp_timebase_i(ramp_timebase_i),
    .remote2_owner_i(remote2_owner_i), .above_start_i(above_start_i),
    .auto_target1_i(t1), .auto_target2_i(t2), .auto_target3_i(t3),
    .fan_drive_output1_o(f1), .fan_drive_output2_o(f2), .fan_drive_output3_o(f3));
  fpr_fan_model u_fpr_fan_model (.clk_i(clk_i), .duty_i(f1), .spin_o(spin));

  // Clock and cycle count
  initial
    forever #12.5 clk_i = ~clk_i;
  always @(posedge clk_i)
    cyc <= cyc + 1;

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] v);
    cmp_count++;
    if (v !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back({a, e});
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask
  // Wait, bounded, until only keep fan notes are left
  task automatic drain(input int keep, input int lim);
    for (int i = 0; i < lim && fq.size() > keep; i++)
      @(posedge clk_i);
    chk("fan1 pending", 8'(keep), 8'(fq.size()));
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Result watcher: read data and each fan 1 change against the oldest note
  always @(posedge clk_i)
    rd_d <= rd_i;
  always @(negedge clk_i)
  begin
    if (rd_d)
    begin
      n = (rq.size() > 0) ? rq.pop_front() : 16'hXXXX;
      chk("rdata", n[7:0], rdata_o);
      if (n[15:8] == DUTY2_OFS)
        chk("fan2", n[7:0], f2);
      if (n[15:8] == DUTY3_OFS)
        chk("fan3", n[7:0], f3);
    end
    if (nrst_i && f1 !== last1)
    begin
      m = (fq.size() > 0) ? fq.pop_front() : 8'hXX;
      chk("fan1", m, f1);
      last1 = f1;
      chg.push_back(cyc);
    end
  end

  // Watchdog
  initial
  begin
    repeat (30000) @(posedge clk_i);
    miscompares++;
    test_done;
  end

  initial
  begin
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    // Reset values, unmapped place, smoothing mask and lock
    for (int i = 0; i < 3; i++)
      rd(8'(8'h64 + i), 8'h80);
    rd(8'h63, 8'h00);
    wr(8'h10, 8'h5A);
    rd(8'h10, 8'h00);
    wr(8'h63, 8'hFF);
    rd(8'h63, 8'h0F);
    lock_i <= 1'b1;
    wr(8'h63, 8'h00);
    rd(8'h63, 8'h0F);
    lock_i <= 1'b0;
    // Floors: random codes, then 0x40, the top code and zero
    for (int i = 0; i < 6; i++)
    begin
      r = (i < 3) ? 8'($random(seed)) : ((i == 3) ? 8'h40 : ((i == 4) ? 8'hFF : 8'h00));
      wr(8'(8'h64 + i % 3), r);
      rd(8'(8'h64 + i % 3), r);
    end
    // Manual mode follows target; auto mode below start is off
    r = 8'($random(seed)) | 8'h01;
    fq.push_back(r);
    t1 <= r;
    t2 <= 8'($random(seed));
    t3 <= 8'($random(seed));
    drain(0, 3);
    rd(8'h51, t2);
    rd(8'h52, t3);
    fq.push_back(8'h00);
    auto_mode_i <= 1'b1;
    drain(0, 3);
    wr(8'h64, 8'hC0);
    rd(8'h64, 8'h40);
    fq.push_back(8'h40);
    t1 <= 8'h10;
    above_start_i <= 3'h1 | 3'($random(seed));
    drain(0, 3);
    fq.push_back(8'h90);
    t1 <= 8'h90;
    drain(0, 3);
    fq.push_back(8'h40);
    t1 <= 8'h40;
    drain(0, 3);
    rd(8'h50, 8'h40);
    rd(8'h51, above_start_i[1] ? 8'hFF : 8'h00);
    rd(8'h52, above_start_i[2] ? t3 : 8'h00);
    // Every rate code: two steps up, two down, one slot apart
    remote2_owner_i <= 3'h1;
    for (int c = 0; c < 8; c++)
    begin
      s = stp[c];
      wr(8'h63, 8'(8 + c));
      ramp_timebase_i <= c[0];
      chg.delete();
      fq.push_back(8'h40 + s);
      fq.push_back(8'h40 + 2 * s);
      fq.push_back(8'h40 + s);
      fq.push_back(8'h40);
      t1 <= 8'h40 + 2 * s;
      drain(2, 4 * SC);
      t1 <= 8'h40;
      drain(0, 4 * SC);
      chk("slot up", 8'(c[0] ? SC : NC), 8'(chg[1] - chg[0]));
      chk("slot down", 8'(c[0] ? SC : NC), 8'(chg[3] - chg[2]));
    end
    // Fastest code clamps at full duty without overshoot
    fq = '{8'h70, 8'hA0, 8'hD0, 8'hFF};
    t1 <= 8'hFF;
    drain(0, 6 * SC);
    // Smoothing off: immediate step to target
    wr(8'h63, 8'h07);
    fq.push_back(8'h40);
    t1 <= 8'h40;
    drain(0, 3);
    chk("spin", 8'h01, {7'h00, spin});
    test_done;
  end
endmodule
